// ==== verilog/shrp_map.svh ====
/*
  constants of the serial host register port: frame layout, register map
  and reset values. assumes inclusion by the package and the port module.
*/
`ifndef SHRP_MAP_SVH
`define SHRP_MAP_SVH

// ------------------------------------------------------------
// frame layout
// ------------------------------------------------------------
`define SHRP_FRAME_CLKS 5'd16
`define SHRP_CMD_CLKS 5'd8
`define SHRP_DATA_W 8
`define SHRP_ADDR_W 7

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define SHRP_REG_NUM 8
`define SHRP_REG_IDX_W 3
`define SHRP_CONFIG_ADDR 7'h00
`define SHRP_STATUS_ADDR 7'h01
`define SHRP_REG_RESET 8'h00
`define SHRP_CFG_LOOP_BIT 0
`define SHRP_CFG_REFSEL_BIT 1
`define SHRP_CFG_CLKOFF_BIT 2

`endif

// ==== verilog/shrp_pkg.sv ====
/*
  types of the serial host register port.
  assumes shrp_map.svh sits on the include path.
*/
`default_nettype none
`include "shrp_map.svh"

package shrp_pkg;
  // ------------------------------------------------------------
  // configuration carried to the transceiver core
  // ------------------------------------------------------------
  typedef struct packed {
    logic tx_source_clock_out_disable;
    logic reference_frequency_select_hi;
    logic loop_timing_no_jitter_atten;
  } shrp_cfg_t;

  // ------------------------------------------------------------
  // frame sequencer states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } shrp_state_t;
endpackage

`default_nettype wire

// ==== verilog/shrp_serial_port.sv ====
/*
  serial host register port: mode strap, four-wire serial register access,
  configuration source select and open-drain alarm interrupt.
  assumes clk at 20 MHz and a host serial clock far slower (400 ns period);
  every pin passes a two-flop synchroniser before logic reads it.
*/
//
// Overview of operation
// R1 - hardware-pin mode when mode select low or floating, host mode when high
// R2 - in host mode configuration comes from registers written over the port
// R3 - both modes give the same functions; only the configuration source differs; code drives the alarm interrupt only in host mode
// R4 - port responds only while chip select low, disabled when it goes high
// R5 - serial pins work only in host mode, else they serve pin functions
// R6 - host raises chip select after every single access, no bursts
// R7 - each complete access spans exactly 16 serial clocks after select low
// R8 - serial data in is sampled on every rising serial clock edge
// R9 - on reads, data out changes on falling edges 8 to 15, LSB first
// R10 - host captures read data on rising edges 9 to 16
// R11 - interrupt driven low on any alarm status change, open drain; code drives it only in host mode, never in hardware mode
// R12 - interrupt released once the host has read the status register
// R13 - first 8 clocks carry read flag and address, last 8 write data LSB first
`timescale 1ns/1ns
`default_nettype none
`include "shrp_map.svh"

module shrp_serial_port
  import shrp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // device pins, asynchronous to clk
  input wire logic control_mode_select,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  output logic sdo_pin,
  output logic int_n_o,
  output logic int_n_oe_n,
  // transceiver core side
  input wire logic [`SHRP_DATA_W-1:0] alarm_status,
  input wire logic pattern_check_error,
  output logic host_mode,
  output shrp_cfg_t cfg
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic sclk_d_reg;
  assign pin_raw = {control_mode_select, cs_n_pin, sclk_pin, sdi_pin};

  // two flops per pin; only stage two is read by anything
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        sync1_reg[gi] <= rst ? 1'b0 : pin_raw[gi];
        sync2_reg[gi] <= rst ? 1'b0 : sync1_reg[gi];
      end
    end
  endgenerate

  logic mode_s, cs_n_s, sclk_s, sdi_s, sclk_rise, sclk_fall;
  assign mode_s = sync2_reg[3];
  assign cs_n_s = sync2_reg[2];
  assign sclk_s = sync2_reg[1];
  assign sdi_s = sync2_reg[0];
  // edges of the host clock as seen by clk
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign host_mode = mode_s; // R1

  // ------------------------------------------------------------
  // frame sequencer and register file
  // ------------------------------------------------------------
  shrp_state_t state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] data_reg, data_next;
  logic [7:0] rd_reg, rd_next;
  logic sdo_reg, sdo_next;
  logic [7:0] regs_reg [`SHRP_REG_NUM];
  logic [7:0] regs_next [`SHRP_REG_NUM];
  logic status_read_done;
  logic [`SHRP_ADDR_W-1:0] addr_now;

  // read value for an address; status reflects live alarms
  function automatic logic [7:0] read_word(input logic [`SHRP_ADDR_W-1:0] a,
                                           input logic [7:0] alarms);
    if (a == `SHRP_STATUS_ADDR) begin
      return alarms;
    end
    return regs_reg[a[`SHRP_REG_IDX_W-1:0]];
  endfunction

  assign addr_now = cmd_reg[7:1];

  // next state: chip select high aborts any frame at once
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    data_next = data_reg;
    rd_next = rd_reg;
    sdo_next = sdo_reg;
    status_read_done = 1'b0;
    for (int i = 0; i < `SHRP_REG_NUM; i++) begin
      regs_next[i] = regs_reg[i];
    end
    if (!mode_s) begin
      // hardware mode: the pin shows the pattern checker flag
      state_next = ST_IDLE; // R5
      cnt_next = 5'd0;
      sdo_next = pattern_check_error; // R5
    end else if (cs_n_s) begin
      state_next = ST_IDLE; // R4
      cnt_next = 5'd0;
      sdo_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_next = ST_CMD;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            // sample on rising edge, flag first then address LSB first
            cmd_next = {sdi_s, cmd_reg[7:1]}; // R8 R13
            cnt_next = cnt_reg + 5'd1;
            if (cnt_reg + 5'd1 == `SHRP_CMD_CLKS) begin
              state_next = ST_DATA;
              rd_next = read_word(cmd_next[7:1], alarm_status);
            end
          end
        end
        ST_DATA: begin
          if (sclk_fall && cmd_reg[0]) begin
            sdo_next = rd_reg[cnt_reg[2:0]]; // R9
          end
          if (sclk_rise) begin
            data_next = {sdi_s, data_reg[7:1]}; // R8 R13
            cnt_next = cnt_reg + 5'd1;
            if (cnt_reg + 5'd1 == `SHRP_FRAME_CLKS) begin
              state_next = ST_DONE; // R7
              if (cmd_reg[0]) begin
                status_read_done = (addr_now == `SHRP_STATUS_ADDR); // R12
              end else if (addr_now != `SHRP_STATUS_ADDR) begin
                regs_next[addr_now[`SHRP_REG_IDX_W-1:0]] = data_next; // R2 R13
              end
            end
          end
        end
        ST_DONE: begin
          // extra clocks are ignored until select rises again
          state_next = ST_DONE; // R6
        end
      endcase
    end
  end

  // register the sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'd0;
      cmd_reg <= 8'h00;
      data_reg <= 8'h00;
      rd_reg <= 8'h00;
      sdo_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      for (int i = 0; i < `SHRP_REG_NUM; i++) begin
        regs_reg[i] <= `SHRP_REG_RESET;
      end
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cmd_reg <= cmd_next;
      data_reg <= data_next;
      rd_reg <= rd_next;
      sdo_reg <= sdo_next;
      sclk_d_reg <= sclk_s;
      for (int i = 0; i < `SHRP_REG_NUM; i++) begin
        regs_reg[i] <= regs_next[i];
      end
    end
  end
  assign sdo_pin = sdo_reg;

  // ------------------------------------------------------------
  // configuration source select
  // ------------------------------------------------------------
  shrp_cfg_t cfg_reg, cfg_next, cfg_pins, cfg_regs;
  // in hardware mode the serial pins carry their strap meanings
  assign cfg_pins = '{tx_source_clock_out_disable: cs_n_s,
                      reference_frequency_select_hi: sclk_s,
                      loop_timing_no_jitter_atten: sdi_s};
  assign cfg_regs = '{
    tx_source_clock_out_disable: regs_reg[0][`SHRP_CFG_CLKOFF_BIT],
    reference_frequency_select_hi: regs_reg[0][`SHRP_CFG_REFSEL_BIT],
    loop_timing_no_jitter_atten: regs_reg[0][`SHRP_CFG_LOOP_BIT]};

  // same fields either way, only the source changes
  always_comb begin
    cfg_next = mode_s ? cfg_regs : cfg_pins; // R1 R2 R3
  end

  always_ff @(posedge clk) begin
    cfg_reg <= rst ? '0 : cfg_next;
  end
  assign cfg = cfg_reg;

  // ------------------------------------------------------------
  // alarm interrupt
  // ------------------------------------------------------------
  logic [7:0] alarm_prev_reg, alarm_prev_next;
  logic int_pend_reg, int_pend_next, alarm_change;

  // a change in the same cycle as the clearing read still wins
  always_comb begin
    alarm_prev_next = alarm_status;
    alarm_change = mode_s && (alarm_status != alarm_prev_reg);
    int_pend_next = mode_s && (alarm_change || (int_pend_reg && !status_read_done)); // R11 R12
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_prev_reg <= 8'h00;
      int_pend_reg <= 1'b0;
    end else begin
      alarm_prev_reg <= alarm_prev_next;
      int_pend_reg <= int_pend_next;
    end
  end
  // open drain: only ever pull low, the board pull-up makes the high
  assign int_n_o = 1'b0;
  assign int_n_oe_n = ~int_pend_reg; // R11

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_last_rise;
    state_reg == ST_DATA && cnt_reg == 5'd15 && sclk_rise && !cs_n_s && mode_s;
  endsequence
  sequence s_read_fall;
    state_reg == ST_DATA && cmd_reg[0] && sclk_fall && !cs_n_s && mode_s;
  endsequence

  a_hw_cfg_pins: assert property (!mode_s |=> cfg == $past(cfg_pins)) // R1
    else $error("hardware mode cfg not from pins");
  a_host_cfg_regs: assert property (mode_s |=> cfg == $past(cfg_regs)) // R2
    else $error("host mode cfg not from registers");
  a_cs_high_idle: assert property (mode_s && cs_n_s |=> state_reg == ST_IDLE) // R4
    else $error("port active with select high");
  a_hw_sdo_pin: assert property (!mode_s |=> sdo_pin == $past(pattern_check_error)) // R5
    else $error("sdo not showing pattern flag");
  a_frame_sixteen: assert property (s_last_rise |=> state_reg == ST_DONE) // R7
    else $error("frame did not end on clock 16");
  a_rise_sample: assert property (state_reg == ST_CMD && sclk_rise && !cs_n_s && mode_s
    |=> cmd_reg[7] == $past(sdi_s) && cnt_reg == $past(cnt_reg) + 5'd1) // R8
    else $error("rising edge sample lost");
  a_sdo_fall: assert property (s_read_fall |=> sdo_pin == $past(rd_reg[cnt_reg[2:0]])) // R9
    else $error("read bit wrong on falling edge");
  a_int_assert: assert property (alarm_change |=> !int_n_oe_n ##0 int_n_o == 1'b0) // R11
    else $error("interrupt not driven on alarm change");
  a_int_release: assert property (status_read_done && !alarm_change |=> int_n_oe_n) // R12
    else $error("interrupt held after status read");
  a_write_commit: assert property ((s_last_rise and (!cmd_reg[0]
    && cmd_reg[7:1] != `SHRP_STATUS_ADDR))
    |=> regs_reg[$past(cmd_reg[`SHRP_REG_IDX_W:1])] == {$past(sdi_s), $past(data_reg[7:1])}) // R13
    else $error("write data not stored");

endmodule // shrp_serial_port
`default_nettype wire

// ==== sim/shrp_host_model.sv ====
/*
  host side model of the serial register port: drives select, serial clock
  and serial data in, captures read data. assumes the device clk (50 ns).
*/
`timescale 1ns/1ns
`default_nettype none

module shrp_host_model (
  // timing reference
  input wire logic clk,
  // serial pins
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic sdi_pin,
  input wire logic sdo_pin
);
  // released pins rest at their pull levels; serial clock stands still
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    sdi_pin = 1'b0;
  end

  // ------------------------------------------------------------
  // one access of nclk serial clocks; fewer than 16 is an abort
  // ------------------------------------------------------------
  task automatic access(input logic rd, input logic [6:0] addr, input logic [7:0] wd,
                        input int nclk, output logic [7:0] rdata);
    logic [15:0] bits;
    bits = {wd, addr, rd};
    rdata = 8'h00;
    @(posedge clk) cs_n_pin <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < nclk; i++) begin
      sdi_pin <= bits[i];
      repeat (4) @(posedge clk);
      sclk_pin <= 1'b1;
      // taken at the rising edge; the bit settled about 3 clk after the fall
      if (i >= 8) rdata[i-8] = sdo_pin;
      repeat (4) @(posedge clk);
      sclk_pin <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n_pin <= 1'b1;
    sdi_pin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // pin levels for hardware mode, where the pins carry configuration
  task automatic set_pins(input logic c, input logic s, input logic d);
    @(posedge clk);
    cs_n_pin <= c;
    sclk_pin <= s;
    sdi_pin <= d;
  endtask
endmodule // shrp_host_model

`default_nettype wire

// ==== sim/test_serial_host_register_port.sv ====
/*
  self-checking bench of the serial host register port.
  assumes the design package and the host model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module test_serial_host_register_port;
  import shrp_pkg::*;
  logic clk, rst, control_mode_select, pattern_check_error;
  logic cs_n_pin, sclk_pin, sdi_pin, sdo_pin, int_n_o, int_n_oe_n, host_mode;
  logic [7:0] alarm_status;
  logic [7:0] rd;
  shrp_cfg_t cfg;
  wire int_n_line;
  int err_count = 0;
  int num_checks = 0;

  // open-drain line with pull-up
  assign int_n_line = int_n_oe_n ? 1'b1 : int_n_o;

  shrp_serial_port dut_u (.clk(clk), .rst(rst), .control_mode_select(control_mode_select),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .sdo_pin(sdo_pin),
    .int_n_o(int_n_o), .int_n_oe_n(int_n_oe_n), .alarm_status(alarm_status),
    .pattern_check_error(pattern_check_error), .host_mode(host_mode), .cfg(cfg));

  shrp_host_model host_u (.clk(clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .sdi_pin(sdi_pin), .sdo_pin(sdo_pin));

  // clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_write_read;
    for (int v = 0; v < 8; v++) begin
      host_u.access(1'b0, 7'h00, v[7:0], 16, rd);
      wait_clk(1);
      chk({5'h00, cfg}, v[7:0], "cfg after write");
      host_u.access(1'b1, 7'h00, 8'h00, 16, rd);
      chk(rd, v[7:0], "config read back");
    end
    // upper address bits alias onto the config register
    host_u.access(1'b0, 7'h08, 8'h05, 16, rd);
    wait_clk(1);
    chk({5'h00, cfg}, 8'h05, "aliased write");
    // a full byte in another register exercises the upper data bits
    host_u.access(1'b0, 7'h02, 8'ha5, 16, rd);
    host_u.access(1'b1, 7'h02, 8'h00, 16, rd);
    chk(rd, 8'ha5, "full byte read back");
    chk({5'h00, cfg}, 8'h05, "other register kept apart");
  endtask

  task automatic t_abort;
    host_u.access(1'b0, 7'h00, 8'h02, 15, rd);
    wait_clk(1);
    chk({5'h00, cfg}, 8'h05, "aborted write kept out");
  endtask

  task automatic t_alarm;
    @(posedge clk) alarm_status <= 8'h5a;
    wait_clk(3);
    chk({7'h00, int_n_line}, 8'h00, "interrupt on alarm");
    host_u.access(1'b0, 7'h01, 8'hff, 16, rd);
    // the status write must not reach the register it aliases onto
    host_u.access(1'b1, 7'h09, 8'h00, 16, rd);
    chk(rd, 8'h00, "status write kept out");
    host_u.access(1'b1, 7'h01, 8'h00, 15, rd);
    chk({7'h00, int_n_line}, 8'h00, "interrupt after short read");
    host_u.access(1'b1, 7'h01, 8'h00, 16, rd);
    chk(rd, 8'h5a, "status read");
    chk({7'h00, int_n_line}, 8'h01, "interrupt released");
  endtask

  task automatic t_hardware;
    @(posedge clk);
    control_mode_select <= 1'b0;
    pattern_check_error <= 1'b1;
    // pin pattern differs from the register value so the source shows
    host_u.set_pins(1'b1, 1'b1, 1'b0);
    wait_clk(8);
    @(posedge clk) alarm_status <= 8'h33;
    wait_clk(3);
    chk({7'h00, host_mode}, 8'h00, "hardware mode");
    chk({5'h00, cfg}, 8'h06, "cfg from pins");
    chk({7'h00, sdo_pin}, 8'h01, "error flag on pin");
    chk({7'h00, int_n_line}, 8'h01, "no interrupt");
    host_u.set_pins(1'b1, 1'b0, 1'b0);
    control_mode_select <= 1'b1;
    wait_clk(8);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    control_mode_select = 1'b1;
    alarm_status = 8'h00;
    pattern_check_error = 1'b0;
    wait_clk(2);
    chk({4'h0, sdo_pin, int_n_line, host_mode, 1'b0}, 8'h04, "reset pins");
    chk({5'h00, cfg}, 8'h00, "reset cfg");
    // third reset edge, released by the update at that edge
    @(posedge clk) rst <= 1'b0;
    wait_clk(6);
    chk({7'h00, host_mode}, 8'h01, "host mode");
    t_write_read();
    t_abort();
    t_alarm();
    t_hardware();
    report_and_stop();
  end

  // watchdog, well past the expected 173 us
  initial begin
    #1000000;
    err_count++;
    report_and_stop();
  end
endmodule // test_serial_host_register_port

`default_nettype wire
